// [logic/ecnt_event_counter.sv]
/*
 * up/down event counter with overflow and underflow flags, pulse-qualified
 * reset-to-zero and reload, APB register slave and a level interrupt.
 * assumes event inputs are asynchronous pins and an APB master on clk.
 */
`timescale 1ns/100ps
module ecnt_event_counter
    import ecnt_pkg::*;
#(
    parameter int LOGIC_CYCLE_US  = LOGIC_CYCLE_US_DEF,
    parameter int TICK_CLKS       = LOGIC_CYCLE_US * 1000 / CLK_PERIOD_NS,
    parameter int MIN_SHORT_TICKS = ecnt_ceil_div(MIN_PULSE_SHORT_MS * 1000, LOGIC_CYCLE_US),
    parameter int MIN_LONG_TICKS  = ecnt_ceil_div(MIN_PULSE_LONG_MS * 1000, LOGIC_CYCLE_US),
    parameter int MAX_TICKS       = MAX_PULSE_MS * 1000 / LOGIC_CYCLE_US
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire ecnt_evt_s         evtIn,
    output ecnt_flag_s             flags,
    output logic      [CNT_W-1:0]  countValue,
    output logic                   irq
);
    if (TICK_CLKS < 2) begin : g_chkTick
        $error("ecnt_event_counter: TICK_CLKS must be at least 2");
    end

    // =====================================================================
    // logic execution cycle
    localparam int TW = $clog2(TICK_CLKS);

    logic [TW-1:0] tickCnt_reg;
    logic          tick;
    logic          tickAdv;

    assign tick    = (tickCnt_reg == TW'(TICK_CLKS - 1));
    assign tickAdv = ce && tick;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tickCnt_reg <= '0;
        end else if (ce) begin
            tickCnt_reg <= tick ? '0 : tickCnt_reg + 1'b1;
        end
    end

    // =====================================================================
    // input conditioning
    ecnt_evt_s evtSync;
    ecnt_cfg_s cfg;
    logic      upPrev_reg;
    logic      dnPrev_reg;
    logic      upEdge;
    logic      dnEdge;
    logic      rzValid;
    logic      rzRej;
    logic      rlValid;
    logic      rlRej;

    ecnt_in_sync #(
        .W (4)
    ) u_sync (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        .pinIn (evtIn),
        .level (evtSync)
    );

    ecnt_pulse_qual #(
        .MIN_SHORT (MIN_SHORT_TICKS),
        .MIN_LONG  (MIN_LONG_TICKS),
        .MAX       (MAX_TICKS)
    ) u_rzQual (
        .clk      (clk),
        .rstn     (rstn),
        .tick     (tickAdv),
        .level    (evtSync.resetZero),
        .longMin  (cfg.rzLong),
        .valid    (rzValid),
        .rejected (rzRej)
    );

    ecnt_pulse_qual #(
        .MIN_SHORT (MIN_SHORT_TICKS),
        .MIN_LONG  (MIN_LONG_TICKS),
        .MAX       (MAX_TICKS)
    ) u_rlQual (
        .clk      (clk),
        .rstn     (rstn),
        .tick     (tickAdv),
        .level    (evtSync.reload),
        .longMin  (cfg.rlLong),
        .valid    (rlValid),
        .rejected (rlRej)
    );

    // edges are judged between two logic-cycle samples only
    assign upEdge = evtSync.up && !upPrev_reg;
    assign dnEdge = evtSync.down && !dnPrev_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            upPrev_reg <= 1'b0;
            dnPrev_reg <= 1'b0;
        end else if (tickAdv) begin
            upPrev_reg <= evtSync.up;
            dnPrev_reg <= evtSync.down;
        end
    end

    // =====================================================================
    // counter core
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             ovf_reg;
    logic             ovf_next;
    logic             unf_reg;
    logic             unf_next;

    always_comb begin
        count_next = count_reg;
        ovf_next   = ovf_reg && !cfg.wrapAuto;
        unf_next   = unf_reg && !cfg.reloadAuto;
        if (rzValid) begin
            count_next = '0;
            ovf_next   = 1'b0;
            unf_next   = 1'b0;
        end else if (rlValid) begin
            count_next = cfg.preset;
            ovf_next   = 1'b0;
            unf_next   = 1'b0;
        end else if (cfg.wrapAuto && count_reg >= cfg.limit) begin
            count_next = '0;
            ovf_next   = 1'b0;
        end else if (cfg.reloadAuto && count_reg == '0) begin
            count_next = cfg.preset;
            unf_next   = 1'b0;
        end else if (upEdge && !dnEdge) begin
            if (count_reg < cfg.limit) begin
                count_next = count_reg + 1'b1;
                ovf_next   = (count_reg + 1'b1 == cfg.limit);
                unf_next   = 1'b0;
            end
        end else if (dnEdge && !upEdge) begin
            if (count_reg != '0) begin
                count_next = count_reg - 1'b1;
                unf_next   = (count_reg == CNT_W'(1));
                ovf_next   = 1'b0;
            end
        end
    end

    // both edges together skip the up and down branches and hold the count unless an earlier branch applies
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count_reg <= '0;
            ovf_reg   <= 1'b0;
            unf_reg   <= 1'b0;
        end else if (tickAdv) begin
            count_reg <= count_next;
            ovf_reg   <= ovf_next;
            unf_reg   <= unf_next;
        end
    end

    assign flags.overflow  = ovf_reg;
    assign flags.underflow = unf_reg;
    assign countValue      = count_reg;

    // =====================================================================
    // apb slave
    logic [3:0]        ctrl_reg;
    logic [CNT_W-1:0]  limit_reg;
    logic [CNT_W-1:0]  preset_reg;
    logic [ST_W-1:0]   status_reg;
    logic [ST_W-1:0]   mask_reg;
    logic [ST_W-1:0]   statusSet;
    logic [31:0]       rdata_reg;
    logic              err_reg;
    logic              have_reg;
    logic              done;
    logic              wrDone;
    logic              stRead;

    function automatic logic ecnt_mapped(input logic [ADDR_W-1:0] a);
        return a == REG_CTRL_OFS || a == REG_LIMIT_OFS || a == REG_PRESET_OFS
            || a == REG_COUNT_OFS || a == REG_STATUS_OFS || a == REG_MASK_OFS;
    endfunction

    function automatic logic [31:0] ecnt_read(input logic [ADDR_W-1:0] a);
        logic [31:0] d;
        d = '0;
        unique case (a)
            REG_CTRL_OFS:   d[3:0]       = ctrl_reg;
            REG_LIMIT_OFS:  d[CNT_W-1:0] = limit_reg;
            REG_PRESET_OFS: d[CNT_W-1:0] = preset_reg;
            REG_COUNT_OFS:  d[CNT_W-1:0] = count_reg;
            REG_STATUS_OFS: d[ST_W-1:0]  = status_reg;
            REG_MASK_OFS:   d[ST_W-1:0]  = mask_reg;
            default:        d            = '0;
        endcase
        return d;
    endfunction

    assign cfg.wrapAuto   = ctrl_reg[CTRL_WRAP_AUTO_BIT];
    assign cfg.reloadAuto = ctrl_reg[CTRL_RELOAD_AUTO_BIT];
    assign cfg.rzLong     = ctrl_reg[CTRL_RZ_LONG_BIT];
    assign cfg.rlLong     = ctrl_reg[CTRL_RL_LONG_BIT];
    assign cfg.limit      = limit_reg;
    assign cfg.preset     = preset_reg;

    assign pready  = ce && have_reg;
    assign prdata  = rdata_reg;
    assign pslverr = err_reg;
    assign done    = psel && penable && pready;
    assign wrDone  = done && pwrite && !err_reg;
    assign stRead  = done && !pwrite && paddr == REG_STATUS_OFS;

    // data is captured one cycle ahead so the access phase sees a register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            have_reg  <= 1'b0;
            rdata_reg <= '0;
            err_reg   <= 1'b0;
        end else if (ce) begin
            if (done) begin
                have_reg <= 1'b0;
            end else if (psel && !have_reg) begin
                have_reg  <= 1'b1;
                rdata_reg <= pwrite ? '0 : ecnt_read(paddr);
                err_reg   <= !ecnt_mapped(paddr);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_reg   <= CTRL_RST;
            limit_reg  <= LIMIT_RST;
            preset_reg <= PRESET_RST;
            mask_reg   <= MASK_RST;
        end else if (wrDone) begin
            if (paddr == REG_CTRL_OFS) begin
                ctrl_reg <= pwdata[3:0];
            end
            if (paddr == REG_LIMIT_OFS) begin
                limit_reg <= pwdata[CNT_W-1:0];
            end
            if (paddr == REG_PRESET_OFS) begin
                preset_reg <= pwdata[CNT_W-1:0];
            end
            if (paddr == REG_MASK_OFS) begin
                mask_reg <= pwdata[ST_W-1:0];
            end
        end
    end

    // =====================================================================
    // interrupt status
    always_comb begin
        statusSet             = '0;
        statusSet[ST_OVF_BIT] = tickAdv && ovf_next && !ovf_reg;
        statusSet[ST_UNF_BIT] = tickAdv && unf_next && !unf_reg;
        statusSet[ST_RZ_BIT]  = rzValid;
        statusSet[ST_RL_BIT]  = rlValid;
        statusSet[ST_REJ_BIT] = rzRej || rlRej;
    end

    // only bits that were reported are cleared, and a new event wins
    always_ff @(posedge clk) begin
        if (!rstn) begin
            status_reg <= '0;
        end else if (ce) begin
            if (stRead) begin
                status_reg <= (status_reg & ~rdata_reg[ST_W-1:0]) | statusSet;
            end else begin
                status_reg <= status_reg | statusSet;
            end
        end
    end

    assign irq = |(status_reg & mask_reg);

    // =====================================================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    logic quiet;
    assign quiet = !rzValid && !rlValid;

    property p_autoWrap;
        (tickAdv && quiet && cfg.wrapAuto && ovf_reg && count_reg == cfg.limit)
            |=> count_reg == '0 && !ovf_reg;
    endproperty
    a_autoWrap: assert property (p_autoWrap) else $error("auto wrap failed");

    property p_manualHold;
        (ovf_reg && !cfg.wrapAuto && !(tickAdv && (dnEdge || !quiet))) |=> ovf_reg;
    endproperty
    a_manualHold: assert property (p_manualHold) else $error("overflow dropped");

    property p_upIgnored;
        (tickAdv && quiet && ovf_reg && !cfg.wrapAuto && upEdge) |=> $stable(count_reg);
    endproperty
    a_upIgnored: assert property (p_upIgnored) else $error("count passed limit");

    property p_autoReload;
        (tickAdv && quiet && cfg.reloadAuto && count_reg == '0
            && !(cfg.wrapAuto && cfg.limit == '0)) |=> count_reg == $past(cfg.preset);
    endproperty
    a_autoReload: assert property (p_autoReload) else $error("auto reload failed");

    property p_unfHold;
        (unf_reg && !cfg.reloadAuto && !(tickAdv && (upEdge || !quiet))) |=> unf_reg;
    endproperty
    a_unfHold: assert property (p_unfHold) else $error("underflow dropped");

    property p_downIgnored;
        (tickAdv && quiet && unf_reg && !cfg.reloadAuto && dnEdge && count_reg == '0)
            |=> count_reg == '0 && unf_reg;
    endproperty
    a_downIgnored: assert property (p_downIgnored) else $error("count below zero");

    property p_priority;
        (tickAdv && !quiet) |=> !ovf_reg && !unf_reg
            && count_reg == ($past(rzValid) ? '0 : $past(cfg.preset));
    endproperty
    a_priority: assert property (p_priority) else $error("reset priority broken");

    property p_countUp;
        (tickAdv && quiet && upEdge && !dnEdge && count_reg < cfg.limit
            && !(cfg.reloadAuto && count_reg == '0)) |=> count_reg == $past(count_reg) + 1'b1;
    endproperty
    a_countUp: assert property (p_countUp) else $error("count up wrong");

    property p_bothEdges;
        (tickAdv && quiet && upEdge && dnEdge && !(cfg.wrapAuto && count_reg >= cfg.limit)
            && !(cfg.reloadAuto && count_reg == '0)) |=> $stable(count_reg);
    endproperty
    a_bothEdges: assert property (p_bothEdges) else $error("both edges moved count");

    property p_onlyOnTick;
        !tickAdv |=> $stable(count_reg) && $stable(ovf_reg) && $stable(unf_reg);
    endproperty
    a_onlyOnTick: assert property (p_onlyOnTick) else $error("change off cycle");

    c_autoWrap:   cover property (tickAdv && ovf_reg && cfg.wrapAuto);
    c_manualUnf:  cover property (unf_reg && !cfg.reloadAuto ##1 unf_reg);
    c_resetZero:  cover property (rzValid);
    c_rejected:   cover property (rzRej || rlRej);

endmodule

// [logic/ecnt_in_sync.sv]
/*
 * three-stage synchroniser for pin-level inputs; a bit changes only once
 * the second and third stages agree.
 * assumes inputs are asynchronous to clk; ce freezes every stage.
 */
`timescale 1ns/100ps
module ecnt_in_sync #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] level
);
    if (W < 1) begin : g_chk
        $error("ecnt_in_sync: W must be at least 1");
    end

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] agree;

    assign agree = ~(s2_reg ^ s3_reg);
    assign level = level_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            level_reg <= '0;
        end else if (ce) begin
            s1_reg    <= pinIn;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= (s3_reg & agree) | (level_reg & ~agree);
        end
    end

endmodule

// [logic/ecnt_pkg.sv]
/*
 * constants, carrier types and helper functions shared by the up/down
 * event counter and its testbench modules.
 * assumes a single 250 MHz clock; everything else is derived from it.
 */
package ecnt_pkg;

    // =====================================================================
    // timing
    localparam int CLK_PERIOD_NS      = 4;
    localparam int LOGIC_CYCLE_US_DEF = 4000;
    localparam int MIN_PULSE_SHORT_MS = 100;
    localparam int MIN_PULSE_LONG_MS  = 350;
    localparam int MAX_PULSE_MS       = 30000;

    // =====================================================================
    // widths
    localparam int CNT_W  = 16;
    localparam int ADDR_W = 8;
    localparam int ST_W   = 5;

    // =====================================================================
    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_LIMIT_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_PRESET_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_COUNT_OFS  = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_MASK_OFS   = 8'h14;

    // =====================================================================
    // field positions
    localparam int CTRL_WRAP_AUTO_BIT   = 0;
    localparam int CTRL_RELOAD_AUTO_BIT = 1;
    localparam int CTRL_RZ_LONG_BIT     = 2;
    localparam int CTRL_RL_LONG_BIT     = 3;
    localparam int ST_OVF_BIT           = 0;
    localparam int ST_UNF_BIT           = 1;
    localparam int ST_RZ_BIT            = 2;
    localparam int ST_RL_BIT            = 3;
    localparam int ST_REJ_BIT           = 4;

    // =====================================================================
    // reset values
    localparam logic [3:0]       CTRL_RST   = 4'h0;
    localparam logic [CNT_W-1:0] LIMIT_RST  = 16'hffff;
    localparam logic [CNT_W-1:0] PRESET_RST = 16'h0001;
    localparam logic [ST_W-1:0]  MASK_RST   = 5'h00;

    // =====================================================================
    // carriers
    typedef struct packed {
        logic             wrapAuto;
        logic             reloadAuto;
        logic             rzLong;
        logic             rlLong;
        logic [CNT_W-1:0] limit;
        logic [CNT_W-1:0] preset;
    } ecnt_cfg_s;

    typedef struct packed {
        logic up;
        logic down;
        logic resetZero;
        logic reload;
    } ecnt_evt_s;

    typedef struct packed {
        logic overflow;
        logic underflow;
    } ecnt_flag_s;

    // =====================================================================
    // helpers
    function automatic int ecnt_ceil_div(input int num, input int den);
        return (num + den - 1) / den;
    endfunction

endpackage

// [logic/ecnt_pulse_qual.sv]
/*
 * low-high-low pulse qualifier measured in logic cycles.
 * assumes tick already carries the clock enable and marks one logic cycle.
 */
`timescale 1ns/100ps
module ecnt_pulse_qual #(
    parameter int MIN_SHORT = 25,
    parameter int MIN_LONG  = 88,
    parameter int MAX       = 7500
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic tick,
    input  wire logic level,
    input  wire logic longMin,
    output logic      valid,
    output logic      rejected
);
    if (MIN_SHORT < 1 || MIN_LONG < MIN_SHORT || MAX < MIN_LONG) begin : g_chk
        $error("ecnt_pulse_qual: need 1 <= MIN_SHORT <= MIN_LONG <= MAX");
    end

    localparam int WW = $clog2(MAX + 2);

    logic [WW-1:0] width_reg;
    logic          prev_reg;
    logic [WW-1:0] minWidth;
    logic          fall;

    assign minWidth = longMin ? WW'(MIN_LONG) : WW'(MIN_SHORT);
    assign fall     = tick && prev_reg && !level;
    // width saturates above MAX so an overlong pulse never qualifies
    assign valid    = fall && width_reg >= minWidth && width_reg <= WW'(MAX);
    assign rejected = fall && !valid;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_reg  <= 1'b0;
            width_reg <= '0;
        end else if (tick) begin
            prev_reg <= level;
            if (level && !prev_reg) begin
                width_reg <= WW'(1);
            end else if (level && width_reg <= WW'(MAX)) begin
                width_reg <= width_reg + 1'b1;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_shortRefused;
        (fall && width_reg < WW'(MIN_SHORT)) |-> !valid && rejected;
    endproperty
    a_shortRefused: assert property (p_shortRefused) else $error("short pulse accepted");

    property p_longMin;
        (valid && longMin) |-> width_reg >= WW'(MIN_LONG) && prev_reg && !level;
    endproperty
    a_longMin: assert property (p_longMin) else $error("long minimum ignored");

    property p_overlong;
        (fall && width_reg > WW'(MAX)) |-> !valid;
    endproperty
    a_overlong: assert property (p_overlong) else $error("overlong pulse accepted");

endmodule

// [tb/ecnt_event_counter_tb_top.sv]
/*
 * self-checking bench: registers over apb, counting, limits, pulse
 * qualification, wrap and reload modes, interrupt.
 * assumes a short tick and small pulse-width counts for a quick run.
 */
`timescale 1ns/100ps
module ecnt_event_counter_tb_top
    import ecnt_pkg::*;
;
    localparam int         TK = 4;
    localparam logic [3:0] UP = 4'h8;
    localparam logic [3:0] DN = 4'h4;
    localparam logic [3:0] RZ = 4'h2;
    localparam logic [3:0] RL = 4'h1;
    localparam logic [7:0]  ROW_A [7] = '{REG_CTRL_OFS, REG_LIMIT_OFS, REG_PRESET_OFS,
        REG_COUNT_OFS, REG_STATUS_OFS, REG_MASK_OFS, 8'h18};
    localparam logic [31:0] ROW_D [7] = '{32'h0, 32'hffff, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic        ROW_E [7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};

    logic              clk;
    logic              rstn;
    logic              ce;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic              e;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic [31:0]       rdv;
    logic [CNT_W-1:0]  countValue;
    logic [CNT_W-1:0]  c0;
    logic [CNT_W-1:0]  c1;
    ecnt_evt_s         evtIn;
    ecnt_flag_s        flags;
    int                fails = 0;
    int                comparisons = 0;
    int                k;

    ecnt_evt_src #(.TICK(TK)) src (.clk(clk), .evt(evtIn));

    ecnt_event_counter #(.TICK_CLKS(TK), .MIN_SHORT_TICKS(2), .MIN_LONG_TICKS(4),
        .MAX_TICKS(10)) dut (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtIn(evtIn),
        .flags(flags), .countValue(countValue), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==========================================================
    // shared tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let register updates of the completing edge settle before checks
        #1;
    endtask

    task automatic ev(input logic [3:0] m, input int t);
        src.pulse(m, t);
        #1;
    endtask

    function automatic logic fl(input logic up);
        return up ? flags.overflow : flags.underflow;
    endfunction

    // one-cycle flag: count when raised, its length, count after
    task automatic flag_len(input logic up);
        src.hold(up ? UP : DN);
        repeat (40) if (fl(up) !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        c0 = countValue;
        k = 0;
        while (fl(up) === 1'b1 && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        c1 = countValue;
        src.hold(4'h0);
        repeat (3 * TK) @(posedge clk);
        #1;
    endtask

    task automatic finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fails++;
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ROW_A[i], 32'h0);
            check("rdata", rdv, ROW_D[i]);
            check("pslverr", e, ROW_E[i]);
        end
        $display("test registers done");
        apb(1'b1, REG_LIMIT_OFS, 32'h3);
        apb(1'b1, REG_PRESET_OFS, 32'h2);
        apb(1'b1, REG_COUNT_OFS, 32'h55);
        repeat (3) ev(UP, 3);
        check("count", countValue, 32'h3);
        check("ovf", flags.overflow, 32'h1);
        ev(UP, 3);
        check("count", countValue, 32'h3);
        check("ovf", flags.overflow, 32'h1);
        ev(DN, 3);
        check("count", countValue, 32'h2);
        check("ovf", flags.overflow, 32'h0);
        ev(UP | DN, 3);
        check("count", countValue, 32'h2);
        repeat (3) ev(DN, 3);
        check("count", countValue, 32'h0);
        check("unf", flags.underflow, 32'h1);
        ev(UP, 3);
        check("count", countValue, 32'h1);
        check("unf", flags.underflow, 32'h0);
        $display("test manual limits done");
        ev(RL, 5);
        check("count", countValue, 32'h2);
        ev(UP, 3);
        check("irq", irq, 32'h0);
        apb(1'b1, REG_MASK_OFS, 32'h1);
        check("irq", irq, 32'h1);
        apb(1'b0, REG_STATUS_OFS, 32'h0);
        check("status", rdv[ST_OVF_BIT], 32'h1);
        check("irq", irq, 32'h0);
        ev(RZ, 5);
        check("count", countValue, 32'h0);
        check("flags", flags, 32'h0);
        ev(UP, 3);
        ev(RZ, 1);
        ev(RZ, 15);
        check("count", countValue, 32'h1);
        apb(1'b0, REG_STATUS_OFS, 32'h0);
        check("status", rdv, 32'h14);
        ev(RZ | RL, 5);
        check("count", countValue, 32'h0);
        apb(1'b1, REG_CTRL_OFS, 32'hc);
        ev(UP, 3);
        ev(RL, 3);
        check("count", countValue, 32'h1);
        ev(RZ, 3);
        check("count", countValue, 32'h1);
        ev(RZ, 5);
        check("count", countValue, 32'h0);
        $display("test pulses and interrupt done");
        apb(1'b1, REG_CTRL_OFS, 32'h1);
        repeat (2) ev(UP, 3);
        flag_len(1'b1);
        check("count", c0, 32'h3);
        check("ovf len", k, TK);
        check("count", c1, 32'h0);
        apb(1'b1, REG_CTRL_OFS, 32'h2);
        ev(4'h0, 3);
        check("count", countValue, 32'h2);
        ev(DN, 3);
        flag_len(1'b0);
        check("count", c0, 32'h0);
        check("unf len", k, TK);
        check("count", c1, 32'h2);
        $display("test auto modes done");
        ce <= 1'b0;
        ev(UP, 3);
        check("count", countValue, 32'h2);
        ce <= 1'b1;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("count", countValue, 32'h0);
        rstn <= 1'b1;
        $display("test reset done");
        finish_test();
    end
endmodule

// [tb/ecnt_evt_src.sv]
/*
 * upstream event source model that drives the counter's event pins.
 * assumes clk is the counter clock and one logic cycle is TICK clocks.
 */
`timescale 1ns/100ps
module ecnt_evt_src
    import ecnt_pkg::*;
#(
    parameter int TICK = 4
) (
    input  wire logic clk,
    output ecnt_evt_s evt
);
    initial evt = '0;

    // ==========================================================
    // pulse: mask high for hiTicks logic cycles, then three low
    task automatic pulse(input logic [3:0] mask, input int hiTicks);
        @(posedge clk);
        evt <= mask;
        repeat (hiTicks * TICK) @(posedge clk);
        evt <= '0;
        repeat (3 * TICK) @(posedge clk);
    endtask

    task automatic hold(input logic [3:0] mask);
        @(posedge clk);
        evt <= mask;
    endtask
endmodule
